/* logic/ddce_top.sv */
// Two DMA controllers of seven channels each, with APB registers.
// Assumes slaves answer on m_ack, data in low lanes.
//
// How it works
// - two controllers of seven channels
// - hardware request or software trigger
// - four programmable priority levels per channel
// - equal priority: lower channel index wins
// - each controller arbitrates on its own
// - independent widths with packing
// - circular mode reloads addresses and count
// - three flags ORed into one interrupt
// - any direction, memory or peripheral
// - flash, RAM and both buses reachable
// - up to 65536 items per block
// - timer edge starts block, not in stop
`default_nettype none
module ddce_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral requests and acknowledges
  input  wire logic [13:0] preq,
  output logic      [13:0] preq_ack,
  // Timer triggers, one per controller, and stop mode
  input  wire logic [1:0]  tim_trig,
  input  wire logic        stop_mode,
  // Memory masters, controller c in slice c
  output logic      [1:0]  m_req,
  output logic      [1:0]  m_we,
  output logic      [3:0]  m_size,
  output logic      [63:0] m_addr,
  output logic      [63:0] m_wdata,
  input  wire logic [63:0] m_rdata,
  input  wire logic [1:0]  m_ack,
  input  wire logic [1:0]  m_err,
  // Channel interrupts
  output logic      [13:0] irq
);
  localparam int NCH = ddce_pkg::NCH;
  localparam int NCC = ddce_pkg::NCH_CTRL;
  localparam int NC  = ddce_pkg::NCTRL;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [NCH-1:0] preq_s;
  logic [NC-1:0]  tim_s;
  logic           stop_s;

  ddce_sync #(.WIDTH(NCH + NC + 1)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({stop_mode, tim_trig, preq}),
    .dout  ({stop_s, tim_s, preq_s})
  );

  // ---------------------------------------------------------------
  // Channel state
  // ---------------------------------------------------------------
  logic [ddce_pkg::CFG_W-1:0] cfg_q [NCH];
  logic [ddce_pkg::CFG_W-1:0] cfg_d [NCH];
  logic [16:0]                rld_q [NCH];
  logic [16:0]                rld_d [NCH];
  logic [16:0]                rem_q [NCH];
  logic [16:0]                rem_d [NCH];
  logic [31:0]                sbase_q [NCH];
  logic [31:0]                sbase_d [NCH];
  logic [31:0]                dbase_q [NCH];
  logic [31:0]                dbase_d [NCH];
  logic [31:0]                scur_q [NCH];
  logic [31:0]                scur_d [NCH];
  logic [31:0]                dcur_q [NCH];
  logic [31:0]                dcur_d [NCH];
  logic [2:0]                 flg_q [NCH];
  logic [2:0]                 flg_d [NCH];
  logic [NCH-1:0]             go_q;
  logic [NCH-1:0]             go_d;
  logic [NC-1:0]              tim_prev_q;
  logic [NCH-1:0]             elig;
  logic [31:0]                prdata_d;

  // Engine events, controller c in slice c
  wire [NC-1:0]   rd_ev;
  wire [NC-1:0]   wr_ev;
  wire [NC-1:0]   er_ev;
  wire [NC-1:0]   wrap_ev;
  wire [4*NC-1:0] eng_gch;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [3:0] ach;
  logic [2:0] areg;
  logic       addr_ok;
  logic       wr_acc;
  logic [3:0] ach_s;

  assign ach     = paddr[ddce_pkg::ADDR_CH_LSB +: 4];
  assign areg    = paddr[ddce_pkg::ADDR_RG_LSB +: 3];
  assign addr_ok = (paddr[ddce_pkg::ADDR_W-1:ddce_pkg::ADDR_CH_LSB+4] == '0)
                   && (ach <= ddce_pkg::CH_LAST)
                   && (areg <= ddce_pkg::REG_FLG);
  assign ach_s   = addr_ok ? ach : 4'h0;
  assign wr_acc  = psel && penable && pwrite && addr_ok;
  // Read data fetched in setup: no wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Read mux, latched in the setup cycle
  always_comb begin
    prdata_d = prdata;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      if (addr_ok) begin
        case (areg)
          ddce_pkg::REG_CFG: prdata_d = 32'(cfg_q[ach_s]);
          ddce_pkg::REG_CNT: prdata_d = 32'(rem_q[ach_s]);
          ddce_pkg::REG_SRC: prdata_d = sbase_q[ach_s];
          ddce_pkg::REG_DST: prdata_d = dbase_q[ach_s];
          ddce_pkg::REG_FLG: prdata_d = 32'(flg_q[ach_s]);
          default:           prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Channel next state: engine, timer, then software
  // ---------------------------------------------------------------
  always_comb begin
    int         c;
    logic       hit;
    logic [2:0] sb;
    logic [2:0] db;
    logic [2:0] set;
    logic [2:0] clr;
    c   = 0;
    hit = 1'b0;
    sb  = 3'h0;
    db  = 3'h0;
    set = 3'h0;
    clr = 3'h0;
    go_d = go_q;
    for (int i = 0; i < NCH; i++) begin
      cfg_d[i]   = cfg_q[i];
      rld_d[i]   = rld_q[i];
      rem_d[i]   = rem_q[i];
      sbase_d[i] = sbase_q[i];
      dbase_d[i] = dbase_q[i];
      scur_d[i]  = scur_q[i];
      dcur_d[i]  = dcur_q[i];
      c   = i / NCC;
      hit = eng_gch[4*c +: 4] == 4'(i);
      sb  = ddce_pkg::size_bytes(cfg_q[i][ddce_pkg::F_SSZ +: 2]);
      db  = ddce_pkg::size_bytes(cfg_q[i][ddce_pkg::F_DSZ +: 2]);
      set = 3'h0;
      clr = 3'h0;
      if (rd_ev[c] && hit) begin
        rem_d[i] = rem_q[i] - 17'h00001;
        if (cfg_q[i][ddce_pkg::F_SINC]) begin
          scur_d[i] = scur_q[i] + 32'(sb);
        end
        if (rem_d[i] == (rld_q[i] >> 1)) begin
          set[ddce_pkg::FL_HT] = 1'b1;
        end
      end
      if (wr_ev[c] && hit) begin
        if (wrap_ev[c]) begin
          set[ddce_pkg::FL_TC] = 1'b1;
          go_d[i] = 1'b0;
          if (cfg_q[i][ddce_pkg::F_CIRC]) begin
            rem_d[i]  = rld_q[i];
            scur_d[i] = sbase_q[i];
            dcur_d[i] = dbase_q[i];
          end else begin
            cfg_d[i][ddce_pkg::F_EN] = 1'b0;
          end
        end else if (cfg_q[i][ddce_pkg::F_DINC]) begin
          dcur_d[i] = dcur_q[i] + 32'(db);
        end
      end
      if (er_ev[c] && hit) begin
        set[ddce_pkg::FL_TE] = 1'b1;
        cfg_d[i][ddce_pkg::F_EN] = 1'b0;
        go_d[i] = 1'b0;
      end
      // Timer edge arms a block; stop masks it
      if (tim_s[c] && !tim_prev_q[c] && !stop_s
          && cfg_q[i][ddce_pkg::F_EN]
          && cfg_q[i][ddce_pkg::F_TRIG +: 2] == ddce_pkg::TRIG_TIM) begin
        go_d[i] = 1'b1;
      end
      if (wr_acc && ach == 4'(i)) begin
        case (areg)
          ddce_pkg::REG_CFG: begin
            cfg_d[i] = pwdata[ddce_pkg::CFG_W-1:0];
            if (pwdata[ddce_pkg::F_EN] && !cfg_q[i][ddce_pkg::F_EN]) begin
              rem_d[i]  = rld_q[i];
              scur_d[i] = sbase_q[i];
              dcur_d[i] = dbase_q[i];
              go_d[i]   = 1'b0;
            end
          end
          // A zero count means the full block
          ddce_pkg::REG_CNT: rld_d[i] = (pwdata[15:0] == 16'h0000) ?
                             ddce_pkg::CNT_MAX : {1'b0, pwdata[15:0]};
          ddce_pkg::REG_SRC: sbase_d[i] = pwdata;
          ddce_pkg::REG_DST: dbase_d[i] = pwdata;
          ddce_pkg::REG_FLG: clr = pwdata[2:0];
          default: clr = 3'h0;
        endcase
      end
      // A new event beats a clear in the same cycle
      flg_d[i] = (flg_q[i] & ~clr) | set;
    end
  end

  // Channel registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_q[i]   <= ddce_pkg::CFG_RST;
        rld_q[i]   <= ddce_pkg::CNT_RST;
        rem_q[i]   <= ddce_pkg::CNT_RST;
        sbase_q[i] <= 32'h0000_0000;
        dbase_q[i] <= 32'h0000_0000;
        scur_q[i]  <= 32'h0000_0000;
        dcur_q[i]  <= 32'h0000_0000;
        flg_q[i]   <= 3'h0;
      end
      go_q       <= '0;
      tim_prev_q <= '0;
      prdata     <= 32'h0000_0000;
    end else begin
      cfg_q      <= cfg_d;
      rld_q      <= rld_d;
      rem_q      <= rem_d;
      sbase_q    <= sbase_d;
      dbase_q    <= dbase_d;
      scur_q     <= scur_d;
      dcur_q     <= dcur_d;
      flg_q      <= flg_d;
      go_q       <= go_d;
      tim_prev_q <= tim_s;
      prdata     <= prdata_d;
    end
  end

  // Eligibility, interrupts, acknowledges
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      case (cfg_q[i][ddce_pkg::F_TRIG +: 2])
        ddce_pkg::TRIG_HW:  elig[i] = preq_s[i];
        ddce_pkg::TRIG_SW:  elig[i] = 1'b1;
        ddce_pkg::TRIG_TIM: elig[i] = go_q[i];
        default:            elig[i] = 1'b0;
      endcase
      elig[i] = elig[i] && cfg_q[i][ddce_pkg::F_EN] && (rem_q[i] != '0);
      irq[i]  = |flg_q[i];
      preq_ack[i] = rd_ev[i / NCC] && eng_gch[4*(i / NCC) +: 4] == 4'(i)
                    && cfg_q[i][ddce_pkg::F_TRIG +: 2] == ddce_pkg::TRIG_HW;
    end
  end

  // ---------------------------------------------------------------
  // One engine and arbiter per controller
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NC; c++) begin : g_eng
    ddce_pkg::ddce_state_type st_q;
    ddce_pkg::ddce_state_type st_d;
    logic [NCC-1:0]   req;
    logic [2*NCC-1:0] prio;
    logic             gv;
    logic [2:0]       gidx;
    logic [2:0]       lch_q;
    logic [2:0]       lch_d;
    logic [31:0]      buf_q;
    logic [31:0]      buf_d;
    logic [2:0]       fill_q;
    logic [2:0]       fill_d;
    logic             last_q;
    logic             last_d;
    logic [3:0]       gch;
    logic [2:0]       sb;
    logic [2:0]       db;
    logic             rd_e;
    logic             wr_e;
    logic             er_e;
    logic             wrap_e;

    always_comb begin
      for (int k = 0; k < NCC; k++) begin
        req[k]          = elig[c*NCC + k];
        prio[2*k +: 2]  = cfg_q[c*NCC + k][ddce_pkg::F_PRIO +: 2];
      end
    end

    ddce_arb #(.N(NCC), .IDX_W(3)) u_arb (
      .clk         (pclk),
      .rst_n       (presetn),
      .req         (req),
      .prio        (prio),
      .grant_valid (gv),
      .grant_idx   (gidx)
    );

    assign gch = 4'(c*NCC) + {1'b0, lch_q};
    assign sb  = ddce_pkg::size_bytes(cfg_q[gch][ddce_pkg::F_SSZ +: 2]);
    assign db  = ddce_pkg::size_bytes(cfg_q[gch][ddce_pkg::F_DSZ +: 2]);

    // Channel keeps engine until its packed word is written
    always_comb begin
      st_d   = st_q;
      lch_d  = lch_q;
      buf_d  = buf_q;
      fill_d = fill_q;
      last_d = last_q;
      rd_e   = 1'b0;
      wr_e   = 1'b0;
      er_e   = 1'b0;
      wrap_e = 1'b0;
      case (st_q)
        ddce_pkg::ST_IDLE: if (gv) begin
          lch_d  = gidx;
          buf_d  = 32'h0000_0000;
          fill_d = 3'h0;
          last_d = 1'b0;
          st_d   = ddce_pkg::ST_READ;
        end
        ddce_pkg::ST_READ: if (m_ack[c]) begin
          if (m_err[c]) begin
            er_e   = 1'b1;
            fill_d = 3'h0;
            st_d   = ddce_pkg::ST_IDLE;
          end else begin
            rd_e   = 1'b1;
            buf_d  = buf_q | ((m_rdata[32*c +: 32] & ddce_pkg::lane_mask(sb))
                     << {fill_q, 3'b000});
            fill_d = fill_q + sb;
            last_d = rem_q[gch] == 17'h00001;
            st_d   = (fill_d >= db || last_d) ? ddce_pkg::ST_WRITE :
                     ddce_pkg::ST_READ;
          end
        end
        ddce_pkg::ST_WRITE: if (m_ack[c]) begin
          if (m_err[c]) begin
            er_e   = 1'b1;
            fill_d = 3'h0;
            st_d   = ddce_pkg::ST_IDLE;
          end else begin
            wr_e   = 1'b1;
            buf_d  = buf_q >> {db, 3'b000};
            fill_d = (fill_q > db) ? fill_q - db : 3'h0;
            wrap_e = last_q && fill_d == 3'h0;
            if (fill_d == 3'h0) begin
              st_d = ddce_pkg::ST_IDLE;
            end else if (fill_d >= db || last_q) begin
              st_d = ddce_pkg::ST_WRITE;
            end else begin
              st_d = ddce_pkg::ST_READ;
            end
          end
        end
        default: st_d = ddce_pkg::ST_IDLE;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q   <= ddce_pkg::ST_IDLE;
        lch_q  <= 3'h0;
        buf_q  <= 32'h0000_0000;
        fill_q <= 3'h0;
        last_q <= 1'b0;
      end else begin
        st_q   <= st_d;
        lch_q  <= lch_d;
        buf_q  <= buf_d;
        fill_q <= fill_d;
        last_q <= last_d;
      end
    end

    // Any space, either side, any direction
    assign m_req[c]          = st_q != ddce_pkg::ST_IDLE;
    assign m_we[c]           = st_q == ddce_pkg::ST_WRITE;
    assign m_size[2*c +: 2]  = m_we[c] ? cfg_q[gch][ddce_pkg::F_DSZ +: 2] :
                               cfg_q[gch][ddce_pkg::F_SSZ +: 2];
    assign m_addr[32*c +: 32]  = m_we[c] ? dcur_q[gch] : scur_q[gch];
    assign m_wdata[32*c +: 32] = buf_q & ddce_pkg::lane_mask(db);
    assign rd_ev[c]          = rd_e;
    assign wr_ev[c]          = wr_e;
    assign er_ev[c]          = er_e;
    assign wrap_ev[c]        = wrap_e;
    assign eng_gch[4*c +: 4] = gch;
  end

  // ---------------------------------------------------------------
  // Checks on channel 0 and on the controller 0 engine
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd0;
    rd_ev[0] && eng_gch[3:0] == 4'h0 && !wr_acc;
  endsequence
  sequence s_last_wr0;
    wr_ev[0] && wrap_ev[0] && eng_gch[3:0] == 4'h0 && !wr_acc;
  endsequence

  chk_cnt_dec: assert property (
    s_rd0 |=> rem_q[0] == $past(rem_q[0]) - 17'h00001)
    else $error("count not decremented per item");
  chk_half_flag: assert property (
    s_rd0 ##0 (rem_q[0] - 17'h00001 == (rld_q[0] >> 1)) |=>
    flg_q[0][ddce_pkg::FL_HT] ##1 irq[0])
    else $error("half flag missing");
  chk_cnt_max: assert property (
    rem_q[0] <= ddce_pkg::CNT_MAX && rld_q[0] <= ddce_pkg::CNT_MAX)
    else $error("count beyond block limit");
  chk_circ_restart: assert property (
    s_last_wr0 ##0 cfg_q[0][ddce_pkg::F_CIRC] |=>
    rem_q[0] == rld_q[0] && cfg_q[0][ddce_pkg::F_EN]
    && scur_q[0] == sbase_q[0] && flg_q[0][ddce_pkg::FL_TC])
    else $error("circular restart wrong");
  chk_err_irq: assert property (
    er_ev[0] && eng_gch[3:0] == 4'h0 && !wr_acc |=>
    irq[0] && !cfg_q[0][ddce_pkg::F_EN])
    else $error("error flag not raised");
  chk_stop_blocks: assert property (
    stop_s && !go_q[0] |=> !go_q[0])
    else $error("timer trigger armed in stop");
  chk_engine_start: assert property (
    g_eng[0].st_q == ddce_pkg::ST_IDLE && elig[0]
    && g_eng[0].gidx == 3'h0 |=>
    g_eng[0].st_q == ddce_pkg::ST_READ ##1 m_req[0])
    else $error("eligible channel not started");
  chk_pack_hold: assert property (
    rd_ev[0] && g_eng[0].fill_d < g_eng[0].db && !g_eng[0].last_d |=>
    g_eng[0].st_q == ddce_pkg::ST_READ && !m_we[0])
    else $error("partial word written early");
endmodule
`default_nettype wire

/* logic/ddce_pkg.sv */
// Shared constants and types of the two-controller DMA engine.
// Assumes 32-bit APB and memory ports.
`default_nettype none
package ddce_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NCTRL    = 2;
  localparam int NCH_CTRL = 7;
  localparam int NCH      = 14;
  localparam int CNT_W    = 17;
  localparam logic [16:0] CNT_MAX = 17'h10000;
  localparam logic [16:0] CNT_RST = 17'h00000;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 12;
  localparam int ADDR_CH_LSB = 5;
  localparam int ADDR_RG_LSB = 2;
  localparam logic [3:0] CH_LAST = 4'hd;
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_CNT = 3'h1;
  localparam logic [2:0] REG_SRC = 3'h2;
  localparam logic [2:0] REG_DST = 3'h3;
  localparam logic [2:0] REG_FLG = 3'h4;

  // ---------------------------------------------------------------
  // Configuration word fields and flag bits
  // ---------------------------------------------------------------
  localparam int CFG_W  = 12;
  localparam int F_EN   = 0;
  localparam int F_TRIG = 1;
  localparam int F_PRIO = 3;
  localparam int F_SSZ  = 5;
  localparam int F_DSZ  = 7;
  localparam int F_CIRC = 9;
  localparam int F_SINC = 10;
  localparam int F_DINC = 11;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
  localparam int FL_HT = 0;
  localparam int FL_TC = 1;
  localparam int FL_TE = 2;

  typedef enum logic [1:0] {
    TRIG_HW  = 2'b00,
    TRIG_SW  = 2'b01,
    TRIG_TIM = 2'b10
  } ddce_trig_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } ddce_state_type;

  // Item bytes of a size code; spare code acts as word
  function automatic logic [2:0] size_bytes(input logic [1:0] sz);
    case (sz)
      2'b00:   size_bytes = 3'h1;
      2'b01:   size_bytes = 3'h2;
      default: size_bytes = 3'h4;
    endcase
  endfunction

  // Low-lane mask covering nb bytes
  function automatic logic [31:0] lane_mask(input logic [2:0] nb);
    case (nb)
      3'h1:    lane_mask = 32'h0000_00ff;
      3'h2:    lane_mask = 32'h0000_ffff;
      default: lane_mask = 32'hffff_ffff;
    endcase
  endfunction
endpackage
`default_nettype wire

/* logic/ddce_sync.sv */
// Two-flop synchroniser for independent levels.
// Assumes slow levels; no word coherence.
`default_nettype none
module ddce_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* logic/ddce_arb.sv */
// Four-level priority arbiter for one controller.
// Assumes stable requests within a cycle.
`default_nettype none
module ddce_arb #(
  parameter int N     = 7,
  parameter int IDX_W = 3
) (
  // Clock and reset, checks only
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Requests and two-bit priorities, 3 is the highest
  input  wire logic [N-1:0]     req,
  input  wire logic [2*N-1:0]   prio,
  // Winner
  output logic                  grant_valid,
  output logic      [IDX_W-1:0] grant_idx
);
  logic [1:0] best;
  logic       hi_pend;
  logic       tie_low;

  // Strict greater-than keeps the lower index on a tie
  always_comb begin
    grant_valid = 1'b0;
    grant_idx   = '0;
    best        = 2'b00;
    for (int k = 0; k < N; k++) begin
      if (req[k] && (!grant_valid || prio[2*k +: 2] > best)) begin
        grant_valid = 1'b1;
        grant_idx   = IDX_W'(k);
        best        = prio[2*k +: 2];
      end
    end
  end

  // Check helpers: a better or tied lower requester
  always_comb begin
    hi_pend = 1'b0;
    tie_low = 1'b0;
    for (int k = 0; k < N; k++) begin
      if (req[k] && prio[2*k +: 2] > best) begin
        hi_pend = 1'b1;
      end
      if (req[k] && prio[2*k +: 2] == best && IDX_W'(k) < grant_idx) begin
        tie_low = 1'b1;
      end
    end
  end

  chk_prio_order: assert property (
    @(posedge clk) disable iff (!rst_n) grant_valid |-> !hi_pend)
    else $error("lower priority channel granted");
  chk_tie_lowidx: assert property (
    @(posedge clk) disable iff (!rst_n)
    grant_valid && $stable(req) && $stable(prio) |->
    !tie_low && $stable(grant_idx))
    else $error("tie not won by lower index");
endmodule
`default_nettype wire

/* test/ddce_mem_model.sv */
// Memory slave and peripheral requesters.
// Assumes data in the low lanes of each slice.
`default_nettype none
module ddce_mem_model (
  // Clock, reset and pace
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  // Memory port, controller c in slice c
  input  wire logic [1:0]  m_req,
  input  wire logic [1:0]  m_we,
  input  wire logic [3:0]  m_size,
  input  wire logic [63:0] m_addr,
  input  wire logic [63:0] m_wdata,
  output logic      [63:0] m_rdata,
  output logic      [1:0]  m_ack,
  output logic      [1:0]  m_err,
  // Peripheral request lines
  input  wire logic [13:0] raise,
  input  wire logic [13:0] preq_ack,
  output logic      [13:0] preq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Storage and timing
  // ---------------------------------------------------------------
  logic [7:0] mem [1024];
  logic [1:0] wt_q [2];
  logic       tog_q;

  function automatic int nb(input logic [1:0] s);
    return (s == 2'b00) ? 1 : (s == 2'b01) ? 2 : 4;
  endfunction

  // Byte pattern shows each source address
  initial foreach (mem[i]) mem[i] = 8'(i);

  // Ack after 0 or 3 waits; writes land at ack
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ack <= '0;
      wt_q  <= '{2'h0, 2'h0};
      preq  <= '0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      preq  <= (preq | raise) & ~preq_ack;
      for (int c = 0; c < 2; c++) begin
        m_ack[c] <= 1'b0;
        wt_q[c]  <= slow ? 2'h3 : 2'h0;
        if (m_req[c] && !m_ack[c] && wt_q[c] != 2'h0)
          wt_q[c] <= wt_q[c] - 2'h1;
        else if (m_req[c] && !m_ack[c])
          m_ack[c] <= 1'b1;
        if (m_ack[c] && m_we[c])
          for (int b = 0; b < nb(m_size[2*c+:2]); b++)
            mem[m_addr[32*c+:10]+10'(b)] <= m_wdata[32*c+8*b+:8];
      end
    end
  end

  // Data only with ack; toggling junk otherwise
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      m_rdata[32*c+:32] = {32{tog_q}} ^ 32'ha5a5a5a5;
      m_err[c] = m_ack[c] && m_addr[32*c+:10] == 10'h3f0;
      if (m_ack[c])
        for (int b = 0; b < 4; b++)
          m_rdata[32*c+8*b+:8] = mem[m_addr[32*c+:10]+10'(b)];
    end
  end
endmodule
`default_nettype wire

/* test/ddce_top_tb.sv */
// Self-checking bench for the two-controller DMA engine.
// Assumes the memory model answers every request.
`default_nettype none
module ddce_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Signals, instances and bus tasks
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        stop_mode, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] preq, preq_ack, irq, raise;
  logic [1:0]  tim_trig, m_req, m_we, m_ack, m_err;
  logic [3:0]  m_size;
  logic [63:0] m_addr, m_wdata, m_rdata;
  int          mismatches, samples_checked;

  ddce_top u_ddce_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .preq, .preq_ack, .tim_trig,
    .stop_mode, .m_req, .m_we, .m_size, .m_addr, .m_wdata, .m_rdata,
    .m_ack, .m_err, .irq);
  ddce_mem_model u_ddce_mem_model (.pclk, .presetn, .slow, .m_req, .m_we,
    .m_size, .m_addr, .m_wdata, .m_rdata, .m_ack, .m_err, .raise,
    .preq_ack, .preq);

  // Bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [11:0] ra(input int ch, input logic [2:0] r);
    return 12'(ch * 32 + r * 4);
  endfunction

  function automatic logic [31:0] mw(input int a);
    return {u_ddce_mem_model.mem[a+3], u_ddce_mem_model.mem[a+2],
            u_ddce_mem_model.mem[a+1], u_ddce_mem_model.mem[a]};
  endfunction

  // Setup, then access held until pready high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input int ch, input logic [2:0] r, input logic [31:0] e);
    apb(1'b0, ra(ch, r), 32'h0);
    check($sformatf("ch%0d reg%0d", ch, r), rd, e);
  endtask

  // Clear flags so a stale event cannot end the wait
  task automatic prog(input int ch, input logic [31:0] cfg, cnt, src, dst);
    apb(1'b1, ra(ch, ddce_pkg::REG_FLG), 32'h7);
    apb(1'b1, ra(ch, ddce_pkg::REG_CNT), cnt);
    apb(1'b1, ra(ch, ddce_pkg::REG_SRC), src);
    apb(1'b1, ra(ch, ddce_pkg::REG_DST), dst);
    apb(1'b1, ra(ch, ddce_pkg::REG_CFG), cfg);
  endtask

  // Complete or error ends the wait, half does not
  task automatic wait_done(input int ch);
    repeat (60) begin
      apb(1'b0, ra(ch, ddce_pkg::REG_FLG), 32'h0);
      if (rd[2:1] != 2'b00) break;
    end
    check("irq", 32'(irq[ch]), 32'h1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [11:0] bad [3] = '{12'h200, 12'h1c0, 12'h014};
    rchk(13, ddce_pkg::REG_CFG, 32'h0);
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0);
      check("slverr", 32'(err), 32'h1);
    end
    prog(5, 32'h1, 32'h0, 32'h0, 32'h0);
    rchk(5, ddce_pkg::REG_CNT, 32'h10000);
    apb(1'b1, ra(5, ddce_pkg::REG_CFG), 32'h0);
  endtask

  task automatic t_pack();
    prog(0, 32'hd03, 32'h4, 32'h10, 32'h40);
    wait_done(0);
    check("pack", mw(64), 32'h13121110);
    rchk(0, ddce_pkg::REG_FLG, 32'h3);
    rchk(0, ddce_pkg::REG_CNT, 32'h0);
    rchk(0, ddce_pkg::REG_CFG, 32'hd02);
    apb(1'b1, ra(0, ddce_pkg::REG_FLG), 32'h7);
    rchk(0, ddce_pkg::REG_FLG, 32'h0);
  endtask

  // Second controller, slow slave, word to bytes
  task automatic t_unpack();
    slow <= 1'b1;
    prog(7, 32'hc43, 32'h1, 32'h40, 32'h80);
    wait_done(7);
    check("unpack", mw(128), 32'h13121110);
    slow <= 1'b0;
  endtask

  task automatic t_prio(input logic [31:0] p1, p2, input logic [13:0] win);
    prog(1, 32'h1 | p1 << 3, 32'h1, 32'h20, 32'h60);
    prog(2, 32'h1 | p2 << 3, 32'h1, 32'h24, 32'h64);
    raise <= 14'h0006;
    @(posedge pclk);
    raise <= 14'h0000;
    repeat (100) if (preq_ack === 14'h0) @(negedge pclk);
    check("first ack", 32'(preq_ack), 32'(win));
    wait_done(1);
    wait_done(2);
  endtask

  task automatic pulse();
    repeat (4) @(posedge pclk);
    tim_trig <= 2'b01;
    repeat (4) @(posedge pclk);
    tim_trig <= 2'b00;
  endtask

  // Edge ignored in stop, then one circular block
  task automatic t_timer();
    stop_mode <= 1'b1;
    prog(3, 32'he05, 32'h1, 32'h10, 32'ha0);
    pulse();
    repeat (30) @(posedge pclk);
    rchk(3, ddce_pkg::REG_FLG, 32'h0);
    stop_mode <= 1'b0;
    pulse();
    wait_done(3);
    check("timer", mw(160) & 32'hff, 32'h10);
    rchk(3, ddce_pkg::REG_CNT, 32'h1);
    rchk(3, ddce_pkg::REG_CFG, 32'he05);
    apb(1'b1, ra(3, ddce_pkg::REG_CFG), 32'h0);
  endtask

  task automatic t_err();
    prog(4, 32'h3, 32'h1, 32'h3f0, 32'h50);
    wait_done(4);
    rchk(4, ddce_pkg::REG_FLG, 32'h4);
    rchk(4, ddce_pkg::REG_CFG, 32'h2);
  endtask

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, stop_mode, slow, presetn} = '0;
    {paddr, pwdata, tim_trig, raise} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pack();
    t_unpack();
    t_prio(32'h0, 32'h2, 14'h0004);
    t_prio(32'h1, 32'h1, 14'h0002);
    t_timer();
    t_err();
    wrap_up();
  end

  // Watchdog far beyond the expected run
  initial begin
    #500000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
